// ### src/sacc_top.sv
/*
  SAR converter control: start source selection, single and burst
  sequencing, 12-bit four-step accumulation, flags and window compare,
  behind an AXI4-Lite slave. Assumes the analog SAR delivers its 10-bit
  code on sar_data when a sub-conversion's last SAR clock arrives, and that
  timer overflow inputs are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps

module sacc_top
  import sacc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [SACC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SACC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer0_ovf,
  input wire logic timer2_ovf,
  input wire logic timer3_ovf,
  input wire logic ext_convert_pin,
  input wire logic [9:0] sar_data,
  output logic analog_power_on,
  output logic low_bias_on,
  output logic [1:0] dac_rotation,
  output logic sar_clk_en,
  output logic sample_start
);

  logic [SACC_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [7:0] ctrl_q;
  logic [2:0] repeat_count_sel;
  logic twelve_bit_sel;
  logic low_bias_sel;
  logic eight_bit_sel;
  logic [4:0] sar_div;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] result;
  logic conv_busy;
  sacc_ctrl_t ctrl;
  sacc_ctrl_t eff_ctrl;
  sacc_state_t state;
  logic pin_q;
  logic start_req;
  logic start_accept;
  logic [4:0] div_cnt;
  logic [5:0] clk_cnt;
  logic [5:0] conv_len;
  logic [6:0] sub_idx;
  logic [6:0] sub_total;
  logic [6:0] next_total;
  logic [15:0] acc;
  logic [15:0] final_sum;
  logic [9:0] sub_code;
  logic sub_end;
  logic finish;
  logic in_window;
  logic ctrl_wr;
  logic bit_wr;
  logic [7:0] bit_mask;

  assign ctrl = sacc_ctrl_t'(ctrl_q);
  // A whole-byte write that sets the busy bit starts with the source and
  // enables it writes, not with those it replaces.
  assign eff_ctrl = ctrl_wr ? sacc_ctrl_t'(wr_data[7:0]) : ctrl;

  // Write address and data are taken independently; the write lands
  // once both are held and no response is pending.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SACC_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        case (wr_addr)
          SACC_ADDR_CONTROL, SACC_ADDR_ACCUM, SACC_ADDR_POWER, SACC_ADDR_RESULT,
          SACC_ADDR_UPPER, SACC_ADDR_LOWER, SACC_ADDR_CONFIG, SACC_ADDR_BITOP: begin
            s_axi_bresp <= SACC_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= SACC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ctrl_wr = do_write && wr_addr == SACC_ADDR_CONTROL && wr_strb[0];
  assign bit_wr = do_write && wr_addr == SACC_ADDR_BITOP && wr_strb[0];
  assign bit_mask = 8'h01 << wr_data[2:0];

  // Read answers one cycle after the address is taken.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SACC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= SACC_RESP_OKAY;
      case (s_axi_araddr)
        SACC_ADDR_CONTROL: s_axi_rdata <= {24'h00_0000, ctrl_q[7:5], conv_busy, ctrl_q[3:0]};
        SACC_ADDR_ACCUM: s_axi_rdata <= {24'h00_0000, twelve_bit_sel, 4'h0, repeat_count_sel};
        SACC_ADDR_POWER: s_axi_rdata <= {24'h00_0000, low_bias_sel, 7'h00};
        SACC_ADDR_RESULT: s_axi_rdata <= {16'h0000, result};
        SACC_ADDR_UPPER: s_axi_rdata <= {16'h0000, upper_limit};
        SACC_ADDR_LOWER: s_axi_rdata <= {16'h0000, lower_limit};
        SACC_ADDR_CONFIG: s_axi_rdata <= {24'h00_0000, 2'b00, eight_bit_sel, sar_div};
        SACC_ADDR_BITOP: s_axi_rdata <= '0;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= SACC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control register: a whole-byte write or a single-bit write; the
  // hardware set of either flag wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= SACC_CONTROL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= {wr_data[7:5], 1'b0, wr_data[3:0]};
      end else if (bit_wr) begin
        ctrl_q <= wr_data[SACC_BITOP_VAL] ? (ctrl_q | bit_mask) & 8'hEF : ctrl_q & ~bit_mask;
      end
      if (finish) begin
        ctrl_q[5] <= 1'b1;
        if (in_window) begin
          ctrl_q[3] <= 1'b1;
        end
      end
    end
  end

  // Configuration registers beside the control register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      repeat_count_sel <= SACC_REPEAT_RST;
      twelve_bit_sel <= 1'b0;
      low_bias_sel <= 1'b0;
      eight_bit_sel <= 1'b0;
      sar_div <= SACC_DIV_RST;
      upper_limit <= SACC_LIMIT_RST;
      lower_limit <= SACC_LIMIT_RST;
    end else if (do_write) begin
      if (wr_addr == SACC_ADDR_ACCUM && wr_strb[0]) begin
        twelve_bit_sel <= wr_data[SACC_TWELVE_BIT];
        repeat_count_sel <= wr_data[2:0];
      end
      if (wr_addr == SACC_ADDR_POWER && wr_strb[0]) begin
        low_bias_sel <= wr_data[SACC_LOW_BIAS_BIT];
      end
      if (wr_addr == SACC_ADDR_CONFIG && wr_strb[0]) begin
        eight_bit_sel <= wr_data[SACC_EIGHT_BIT];
        sar_div <= wr_data[4:0];
      end
      if (wr_addr == SACC_ADDR_UPPER) begin
        if (wr_strb[0]) upper_limit[7:0] <= wr_data[7:0];
        if (wr_strb[1]) upper_limit[15:8] <= wr_data[15:8];
      end
      if (wr_addr == SACC_ADDR_LOWER) begin
        if (wr_strb[0]) lower_limit[7:0] <= wr_data[7:0];
        if (wr_strb[1]) lower_limit[15:8] <= wr_data[15:8];
      end
    end
  end

  // External pin edge detector; the pin is taken as synchronous.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= ext_convert_pin;
    end
  end

  always_comb begin
    start_req = 1'b0;
    if (eff_ctrl.src[2]) begin
      start_req = ext_convert_pin && !pin_q;
    end else begin
      case (eff_ctrl.src)
        SACC_SRC_SOFT: start_req = (ctrl_wr && wr_data[4])
                                   || (bit_wr && wr_data[2:0] == 3'd4 && wr_data[SACC_BITOP_VAL]);
        SACC_SRC_TMR0: start_req = timer0_ovf;
        SACC_SRC_TMR2: start_req = timer2_ovf;
        SACC_SRC_TMR3: start_req = timer3_ovf;
        default: start_req = 1'b0;
      endcase
    end
  end

  // A disabled converter ignores starts unless burst wakes it.
  assign start_accept = start_req && state == SACC_IDLE && (eff_ctrl.on || eff_ctrl.burst);

  always_comb begin
    next_total = 7'd1;
    if (eff_ctrl.burst) begin
      case (repeat_count_sel)
        3'd1: next_total = 7'd4;
        3'd2: next_total = 7'd8;
        3'd3: next_total = 7'd16;
        3'd4: next_total = 7'd32;
        3'd5: next_total = 7'd64;
        default: next_total = 7'd1;
      endcase
    end
    if (twelve_bit_sel && next_total < SACC_SUBS_12BIT) begin
      next_total = SACC_SUBS_12BIT;
    end
  end

  // In 12-bit mode each sub-conversion takes the 10-bit length, so four
  // of them cost 52 SAR clocks.
  assign conv_len = (eight_bit_sel && !twelve_bit_sel) ? SACC_CLKS_8BIT : SACC_CLKS_10BIT;
  assign sub_code = (eight_bit_sel && !twelve_bit_sel) ? {sar_data[9:2], 2'b00} : sar_data;
  assign sub_end = state == SACC_CONV && sar_clk_en && clk_cnt == conv_len - 6'd1;
  assign finish = sub_end && sub_idx == sub_total - 7'd1;
  assign final_sum = acc + {6'h00, sub_code};
  assign in_window = final_sum > upper_limit && final_sum < lower_limit;

  // SAR clock enable divided from clk, restarted with each conversion.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      sar_clk_en <= 1'b0;
    end else if (state != SACC_CONV || start_accept || finish) begin
      div_cnt <= '0;
      sar_clk_en <= 1'b0;
    end else if (div_cnt == sar_div) begin
      div_cnt <= '0;
      sar_clk_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 5'd1;
      sar_clk_en <= 1'b0;
    end
  end

  // Sequencer: one start runs every sub-conversion of a burst or of a
  // 12-bit group and sums them; the sum is published only at the end.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SACC_IDLE;
      conv_busy <= 1'b0;
      clk_cnt <= '0;
      sub_idx <= '0;
      sub_total <= 7'd1;
      acc <= '0;
      result <= '0;
      dac_rotation <= 2'b00;
      sample_start <= 1'b0;
    end else begin
      sample_start <= 1'b0;
      case (state)
        SACC_IDLE: begin
          if (start_accept) begin
            state <= SACC_CONV;
            conv_busy <= 1'b1;
            clk_cnt <= '0;
            sub_idx <= '0;
            sub_total <= next_total;
            acc <= '0;
            dac_rotation <= 2'b00;
            sample_start <= 1'b1;
          end
        end
        SACC_CONV: begin
          if (sar_clk_en) begin
            clk_cnt <= sub_end ? 6'd0 : clk_cnt + 6'd1;
          end
          if (sub_end) begin
            acc <= final_sum;
            sub_idx <= sub_idx + 7'd1;
            dac_rotation <= dac_rotation + 2'd1;
            if (finish) begin
              state <= SACC_IDLE;
              conv_busy <= 1'b0;
              result <= final_sum;
            end else begin
              sample_start <= 1'b1;
            end
          end
        end
        default: state <= SACC_IDLE;
      endcase
    end
  end

  // Analog power and bias follow the enable, the busy state and the
  // low-bias select.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_power_on <= 1'b0;
      low_bias_on <= 1'b0;
    end else begin
      analog_power_on <= ctrl.on || conv_busy || start_accept;
      low_bias_on <= low_bias_sel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_start_busy;
    start_accept |=> conv_busy && sample_start;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

  property p_done_set;
    finish |=> ctrl_q[5] && !conv_busy && result == $past(final_sum);
  endproperty
  a_done_set: assert property (p_done_set) else $error("finish did not set done");

  property p_soft_gate;
    (ctrl_wr && wr_data[4] && wr_data[2:0] != SACC_SRC_SOFT && !wr_data[2]
      && state == SACC_IDLE && !timer0_ovf && !timer2_ovf && !timer3_ovf) |=> !conv_busy;
  endproperty
  a_soft_gate: assert property (p_soft_gate) else $error("busy write started wrong source");

  property p_twelve_max;
    (finish && twelve_bit_sel && sub_total == 7'd4) |=> result <= 16'd4092;
  endproperty
  a_twelve_max: assert property (p_twelve_max) else $error("12-bit result above 4092");

  property p_len_bound;
    state == SACC_CONV |-> clk_cnt < conv_len;
  endproperty
  a_len_bound: assert property (p_len_bound) else $error("SAR clock count overran");

  property p_rotate;
    (sub_end && !finish) |=> dac_rotation == $past(dac_rotation) + 2'd1 ##1 !sample_start;
  endproperty
  a_rotate: assert property (p_rotate) else $error("DAC rotation did not advance");

  property p_window;
    (finish && in_window) |=> ctrl_q[3];
  endproperty
  a_window: assert property (p_window) else $error("window flag not set");

  property p_power;
    conv_busy |=> analog_power_on;
  endproperty
  a_power: assert property (p_power) else $error("converter off during conversion");

  property p_bias;
    $rose(low_bias_sel) |=> low_bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("low bias not applied");

  property p_disabled;
    (start_req && !eff_ctrl.on && !eff_ctrl.burst && state == SACC_IDLE) |=> !conv_busy;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled converter started");

endmodule

// ### src/sacc_pkg.sv
/*
  Shared constants and types of the SAR converter control block: register
  byte addresses, field positions, reset values, repeat and clock counts.
  Assumes a 32-bit AXI4-Lite register bus and a 12-bit byte address.
*/
package sacc_pkg;

  localparam int SACC_ADDR_W = 12;

  // Register byte addresses.
  localparam logic [11:0] SACC_ADDR_CONTROL = 12'h0_0E8;
  localparam logic [11:0] SACC_ADDR_ACCUM = 12'h0_0EC;
  localparam logic [11:0] SACC_ADDR_POWER = 12'h0_0F0;
  localparam logic [11:0] SACC_ADDR_RESULT = 12'h0_0F4;
  localparam logic [11:0] SACC_ADDR_UPPER = 12'h0_0F8;
  localparam logic [11:0] SACC_ADDR_LOWER = 12'h0_0FC;
  localparam logic [11:0] SACC_ADDR_CONFIG = 12'h0_100;
  localparam logic [11:0] SACC_ADDR_BITOP = 12'h0_104;

  // Field positions.
  localparam int SACC_TWELVE_BIT = 7;
  localparam int SACC_LOW_BIAS_BIT = 7;
  localparam int SACC_EIGHT_BIT = 5;
  localparam int SACC_BITOP_VAL = 3;

  // Reset values.
  localparam logic [7:0] SACC_CONTROL_RST = 8'h00;
  localparam logic [2:0] SACC_REPEAT_RST = 3'h0;
  localparam logic [4:0] SACC_DIV_RST = 5'h1F;
  localparam logic [15:0] SACC_LIMIT_RST = 16'h0000;

  // SAR clocks per conversion, and sub-conversions per 12-bit result.
  localparam logic [5:0] SACC_CLKS_8BIT = 6'd11;
  localparam logic [5:0] SACC_CLKS_10BIT = 6'd13;
  localparam logic [6:0] SACC_SUBS_12BIT = 7'd4;

  // Start source selections.
  localparam logic [2:0] SACC_SRC_SOFT = 3'b000;
  localparam logic [2:0] SACC_SRC_TMR0 = 3'b001;
  localparam logic [2:0] SACC_SRC_TMR2 = 3'b010;
  localparam logic [2:0] SACC_SRC_TMR3 = 3'b011;

  localparam logic [1:0] SACC_RESP_OKAY = 2'b00;
  localparam logic [1:0] SACC_RESP_SLVERR = 2'b10;

  // Control register layout, most significant bit first.
  typedef struct packed {
    logic on;
    logic burst;
    logic done;
    logic busy;
    logic win;
    logic [2:0] src;
  } sacc_ctrl_t;

  typedef enum logic {SACC_IDLE, SACC_CONV} sacc_state_t;

endpackage

// ### testbench/sacc_sar_model.sv
/*
  Behavioural stand-in for the analog SAR array behind the control block.
  Assumes sample_start marks each sub-conversion and that dac_rotation names
  the reference step in use for it.
*/
`timescale 1ns/1ps
module sacc_sar_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_start,
  input wire logic [1:0] dac_rotation,
  input wire logic [9:0] code_base,
  input wire logic code_spread,
  output logic [9:0] sar_data
);
  // Each reference step offsets the code by its own index, so a sum that
  // skips a step or repeats one comes out wrong.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sar_data <= 10'h000;
    end else if (sample_start) begin
      sar_data <= code_base + (code_spread ? {8'h00, dac_rotation} : 10'h000);
    end
  end
endmodule

// ### testbench/sacc_top_test.sv
/*
  Self-checking bench of the SAR converter control block over AXI4-Lite.
  Assumes the SAR model answers every sub-conversion with a set code.
*/
`timescale 1ns/1ps
module sacc_top_test
  import sacc_pkg::*;
;
  localparam logic [1:0] OK = SACC_RESP_OKAY;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, t0, t2, t3, ext, spread;
  logic awready, wready, bvalid, arready, rvalid, pwr, lbias, sclk, sstart;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, rmask;
  logic [1:0] bresp, rresp, last_resp, rot;
  logic [9:0] base, sar_data;
  int error_cnt, num_checks, n_sub, n_clk;

  sacc_top u_sacc_top (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_ovf(t0), .timer2_ovf(t2), .timer3_ovf(t3), .ext_convert_pin(ext),
    .sar_data(sar_data), .analog_power_on(pwr), .low_bias_on(lbias),
    .dac_rotation(rot), .sar_clk_en(sclk), .sample_start(sstart)
  );
  sacc_sar_model u_sacc_sar_model (
    .clk(clk), .rst_b(rst_b), .sample_start(sstart), .dac_rotation(rot),
    .code_base(base), .code_spread(spread), .sar_data(sar_data)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (sstart) begin
      n_sub++;
      rmask[rot] = 1'b1;
    end
    if (sclk) begin
      n_clk++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = OK);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      da = da | awready;
      dw = dw | wready;
      @(posedge clk);
      awvalid <= !da;
      wvalid <= !dw;
    end
    do @(negedge clk); while (!bvalid);
    chk(32'(bresp), 32'(er));
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    last_resp = rresp;
    @(posedge clk);
  endtask

  // Starts one conversion or burst, polls for completion, then checks flags and sum.
  task automatic conv(input logic [7:0] ctl, input logic [15:0] res, input logic win);
    logic [31:0] v;
    int n;
    @(negedge clk);
    n_sub = 0;
    n_clk = 0;
    rmask = 4'h0;
    @(posedge clk);
    wr(SACC_ADDR_CONTROL, {24'h00_0000, ctl});
    t0 <= (ctl[2:0] == 3'h1);
    t2 <= (ctl[2:0] == 3'h2);
    t3 <= (ctl[2:0] == 3'h3);
    ext <= ctl[2];
    @(posedge clk);
    {t0, t2, t3, ext} <= 4'h0;
    rd(SACC_ADDR_CONTROL, v);
    chk(32'(v[4]), 32'h1);
    n = 0;
    while (!v[5] && n < 600) begin
      rd(SACC_ADDR_CONTROL, v);
      n++;
    end
    chk(v, {24'h00_0000, ctl[7:6], 2'b10, win, ctl[2:0]});
    rd(SACC_ADDR_RESULT, v);
    chk(v, {16'h0000, res});
  endtask

  task automatic t_reset();
    logic [31:0] v;
    rd(SACC_ADDR_CONTROL, v);
    chk(v, 32'h0000_0000);
    rd(SACC_ADDR_CONFIG, v);
    chk(v, 32'h0000_001F);
    rd(12'h200, v);
    chk({v[29:0], last_resp}, {30'h0, SACC_RESP_SLVERR});
    wr(12'h200, 32'h0000_00FF, SACC_RESP_SLVERR);
    wr(SACC_ADDR_BITOP, 32'h0000_000F);
    rd(SACC_ADDR_CONTROL, v);
    chk(v, 32'h0000_0080);
    chk(32'(pwr), 32'h1);
    wr(SACC_ADDR_BITOP, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk(32'(pwr), 32'h0);
  endtask

  // Starts without enable, with a non-software source, or from the wrong timer.
  task automatic t_refuse();
    logic [31:0] v;
    wr(SACC_ADDR_CONTROL, 32'h0000_0010);
    wr(SACC_ADDR_CONTROL, 32'h0000_0091);
    t2 <= 1'b1;
    @(posedge clk);
    t2 <= 1'b0;
    repeat (20) @(posedge clk);
    rd(SACC_ADDR_CONTROL, v);
    chk(v, 32'h0000_0081);
    chk(32'(n_sub), 32'h0);
  endtask

  task automatic t_single();
    wr(SACC_ADDR_CONFIG, 32'h0000_0000);
    base <= 10'h2A5;
    conv(8'h90, 16'h02A5, 1'b0);
    chk(32'(n_clk), 32'h0000_000D);
    wr(SACC_ADDR_CONFIG, 32'h0000_0020);
    conv(8'h90, 16'h02A4, 1'b0);
    chk(32'(n_clk), 32'h0000_000B);
    wr(SACC_ADDR_CONFIG, 32'h0000_0000);
  endtask

  task automatic t_sources();
    for (int s = 1; s < 8; s++) begin
      conv(8'h80 | 8'(s), 16'h02A5, 1'b0);
    end
  endtask

  // The bounds are exclusive, so a result equal to a limit stays outside.
  task automatic t_window();
    wr(SACC_ADDR_UPPER, 32'h0000_000A);
    wr(SACC_ADDR_LOWER, 32'h0000_0064);
    base <= 10'h032;
    conv(8'h90, 16'h0032, 1'b1);
    base <= 10'h064;
    conv(8'h90, 16'h0064, 1'b0);
    wr(SACC_ADDR_UPPER, 32'h0000_0000);
    wr(SACC_ADDR_LOWER, 32'h0000_0000);
  endtask

  task automatic t_twelve();
    wr(SACC_ADDR_ACCUM, 32'h0000_0081);
    base <= 10'h064;
    spread <= 1'b1;
    conv(8'hD0, 16'h0196, 1'b0);
    chk(32'(rmask), 32'h0000_000F);
    chk(32'(n_clk), 32'h0000_0034);
    spread <= 1'b0;
    base <= 10'h3FF;
    conv(8'h83, 16'h0FFC, 1'b0);
    wr(SACC_ADDR_ACCUM, 32'h0000_0083);
    conv(8'hD0, 16'h3FF0, 1'b0);
    chk(32'(n_sub), 32'h0000_0010);
    wr(SACC_ADDR_ACCUM, 32'h0000_0000);
  endtask

  task automatic t_repeat();
    base <= 10'h001;
    for (int r = 0; r < 6; r++) begin
      wr(SACC_ADDR_ACCUM, 32'(r));
      conv(8'hD0, 16'((r == 0) ? 1 : 2 << r), 1'b0);
      chk(32'(n_sub), 32'((r == 0) ? 1 : 2 << r));
    end
    conv(8'h90, 16'h0001, 1'b0);
    chk(32'(n_sub), 32'h0000_0001);
    wr(SACC_ADDR_ACCUM, 32'h0000_0000);
  endtask

  task automatic t_power();
    wr(SACC_ADDR_POWER, 32'h0000_0080);
    @(negedge clk);
    chk(32'(lbias), 32'h1);
    @(posedge clk);
    wr(SACC_ADDR_POWER, 32'h0000_0000);
    @(negedge clk);
    chk(32'(lbias), 32'h0);
    @(posedge clk);
    conv(8'h50, 16'h0001, 1'b0);
    @(negedge clk);
    chk(32'(pwr), 32'h0);
    @(posedge clk);
    conv(8'hD0, 16'h0001, 1'b0);
    @(negedge clk);
    chk(32'(pwr), 32'h1);
    @(posedge clk);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    {rst_b, awvalid, wvalid, arvalid, t0, t2, t3, ext, spread} = '0;
    {bready, rready} = 2'b11;
    wstrb = 4'hF;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    base = 10'h000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_refuse();
    t_single();
    t_sources();
    t_window();
    t_twelve();
    t_repeat();
    t_power();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
